// ==== rtl/serial_host_port_map.vh ====
// serial_host_port_map.vh: address, field and strap constants of the serial host port.
// assumes inclusion by bare name from the port's design files.
`ifndef SERIAL_HOST_PORT_MAP_VH
`define SERIAL_HOST_PORT_MAP_VH

// two-wire target address, 7-bit form of base 8'h90
`define TW_BASE_ADDR7     7'h48
// strap codes, one per pin
`define STRAP_SUPPLY      2'h0
`define STRAP_GROUND      2'h1
`define STRAP_CLOCK       2'h2
`define STRAP_DATA        2'h3
// sub-address, command and address byte fields
`define SUB_INDEX_MSB     6
`define SUB_INDEX_LSB     3
`define SUB_CHAN_MSB      2
`define SUB_CHAN_LSB      1
`define SUB_CHAN_VALID    2'h0
`define SPI_DIR_BIT       7
`define TW_DIR_BIT        0
// index of the holding register (tx tail on write, rx head on read)
`define IDX_TX_HOLDING    4'h0
// data returned when the receive stream is empty
`define RX_EMPTY_DATA     8'h00
// cycles a strap input is allowed to settle after reset release
`define STRAP_SETTLE      2'h2

`endif

// ==== rtl/pair_buffer.v ====
// pair_buffer.v: small first-in first-out buffer with valid/ready on both sides.
// assumes one clock domain; depth is a power of two.
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 8,
  parameter DEPTH = 2
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr;
  reg [AW-1:0]    rptr;
  reg [AW:0]      count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  assign in_ready  = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  // entries are flip-flops, so the head word comes straight from a register
  assign out_data  = mem[rptr];

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr  <= {AW{1'b0}};
      rptr  <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wptr <= wptr + 1'b1;
      if (pop)
        rptr <= rptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end

  always @(posedge clk) begin
    if (push)
      mem[wptr] <= in_data;
  end
endmodule // pair_buffer

// ==== rtl/serial_host_register_port.v ====
// serial_host_register_port.v: slave-side two-wire / four-wire host port of the uart bridge.
// assumes the uart core sits on the user ports; all pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`include "serial_host_port_map.vh"

// Behaviour
// - The two-wire port works at standard rate up to 100 kbps and fast rate up to 400 kbps.
// - The port acknowledges each written byte by holding data low through one clock-high period.
// - A write to the transmit stream while it is full is answered with a not-acknowledge; on four wires the byte is dropped instead.
// - The address is base 0x90 plus the two strap codes, high pin first, each strap tied to supply, ground, clock or data.
// - Address bit 0 high means read from the port and low means write to it.
// - Sub-address bits 6:3 are the register index, bits 2:1 the channel (only 00 valid), bits 7 and 0 reserved.
// - The four-wire clock and data lines are meant to run up to 33 MHz; sampling at 25 MHz holds the port's four-wire clock well below that.
// - The first four-wire byte holds direction in bit 7 (1 read), index in 6:3, channel in 2:1, bit 0 reserved.
// - One four-wire sequence may stream up to 64 bytes into the transmit or out of the receive stream.
// - Index 0 with divisor access clear writes the transmit tail and reads the receive head.
module serial_host_register_port #(
  parameter BUF_DEPTH = 2
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       arst_n,
  // shared serial clock pin and mode strap (high selects four-wire)
  input  wire       scl_in,
  input  wire       spi_select,
  // two-wire data pin, open drain
  input  wire       sda_in,
  output wire       sda_out,
  output wire       sda_oe,
  // four-wire pins
  input  wire       spi_cs_n,
  input  wire       spi_si,
  output wire       spi_so,
  output wire       spi_so_oe,
  // address straps
  input  wire       addr_strap_high,
  input  wire       addr_strap_low,
  // uart core side
  input  wire       divisor_access,
  output wire       tx_valid,
  input  wire       tx_ready,
  output wire [7:0] tx_data,
  input  wire       rx_valid,
  output wire       rx_ready,
  input  wire [7:0] rx_data,
  output wire       reg_wr,
  output wire       reg_rd,
  output wire [3:0] reg_index,
  output wire [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  localparam ST_IDLE  = 10'h001;
  localparam ST_ADDR  = 10'h002;
  localparam ST_ACK   = 10'h004;
  localparam ST_SUB   = 10'h008;
  localparam ST_WDATA = 10'h010;
  localparam ST_RDATA = 10'h020;
  localparam ST_RACK  = 10'h040;
  localparam ST_SCMD  = 10'h080;
  localparam ST_SWR   = 10'h100;
  localparam ST_SRD   = 10'h200;

  // strap code from samples at start (scl 1, sda 0), first rise (sda 1) and first fall (scl 0)
  function [1:0] strap_code;
    input at_start;
    input at_rise;
    input at_fall;
    begin
      if (at_start & at_fall)
        strap_code = `STRAP_SUPPLY;
      else if (at_start)
        strap_code = `STRAP_CLOCK;
      else if (at_rise)
        strap_code = `STRAP_DATA;
      else
        strap_code = `STRAP_GROUND;
    end
  endfunction

  // two-flop synchronisers; the first stage feeds only the second
  wire [6:0] raw = {scl_in, sda_in, spi_cs_n, spi_si, addr_strap_high, addr_strap_low, spi_select};
  reg  [6:0] meta;
  reg  [6:0] sync;
  reg  [2:0] prev;
  wire scl_s = sync[6];
  wire sda_s = sync[5];
  wire cs_s  = sync[4];
  wire si_s  = sync[3];
  wire scl_rise = scl_s & ~prev[2];
  wire scl_fall = ~scl_s & prev[2];

  reg  [1:0] boot_cnt;
  reg        spi_mode;
  // start/stop seen only while the clock stays high
  wire tw_start = ~spi_mode & scl_s & prev[2] & prev[1] & ~sda_s;
  wire tw_stop  = ~spi_mode & scl_s & prev[2] & ~prev[1] & sda_s;

  reg  [9:0] state;
  reg  [9:0] ack_next;
  reg  [2:0] bit_cnt;
  reg  [7:0] sh_in;
  reg  [7:0] sh_out;
  reg  [3:0] cur_index;
  reg        chan_ok;
  reg        nack;
  reg        ack_phase;
  reg        rack_ok;
  reg        peek_ok;
  reg        sda_drive;
  reg        so_bit;
  reg        so_en;
  reg        wr_go;
  reg  [7:0] wr_byte;
  reg  [1:0] strap_a;
  reg  [1:0] strap_b;
  reg  [1:0] strap_c;

  wire [7:0] byte_in = {sh_in[6:0], (spi_mode ? si_s : sda_s)};
  wire [6:0] own_addr7 = `TW_BASE_ADDR7 +
    {3'h0, strap_code(strap_a[1], strap_b[1], strap_c[1]),
     strap_code(strap_a[0], strap_b[0], strap_c[0])};
  wire is_fifo = (cur_index == `IDX_TX_HOLDING) & ~divisor_access;
  wire [7:0] fetch_data = is_fifo ? (rx_valid ? rx_data : `RX_EMPTY_DATA) : reg_rdata;
  wire buf_in_ready;
  wire byte_done = scl_rise & (bit_cnt == 3'h7);

  // moment a read byte is fetched and its first bit is driven
  wire load_now =
    (state == ST_ACK & ack_phase & scl_fall & ack_next == ST_RDATA) |
    (state == ST_RACK & ack_phase & scl_fall & rack_ok) |
    (state == ST_SRD & scl_fall & bit_cnt == 3'h0 & ~cs_s);
  wire rd_go = load_now & chan_ok;

  // four-wire pops only at the byte's first rise, so a head peeked before deselect stays queued
  assign rx_ready  = (state == ST_SRD) ? (scl_rise & bit_cnt == 3'h0 & ~cs_s & peek_ok)
                                       : (rd_go & is_fifo & rx_valid);
  assign reg_rd    = rd_go & ~is_fifo;
  assign reg_wr    = wr_go & ~is_fifo;
  assign reg_wdata = wr_byte;
  assign reg_index = cur_index;
  assign sda_out   = 1'b0;
  assign sda_oe    = sda_drive;
  assign spi_so    = so_bit;
  assign spi_so_oe = so_en;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta     <= 7'h00;
      sync     <= 7'h00;
      prev     <= 3'h0;
      boot_cnt <= 2'h0;
      spi_mode <= 1'b0;
    end else begin
      meta <= raw;
      sync <= meta;
      prev <= {scl_s, sda_s, cs_s};
      if (boot_cnt != 2'h3)
        boot_cnt <= boot_cnt + 2'h1;
      // mode strap caught once, after the synchroniser has settled
      if (boot_cnt == `STRAP_SETTLE)
        spi_mode <= sync[0];
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_IDLE;
      ack_next  <= ST_IDLE;
      bit_cnt   <= 3'h0;
      sh_in     <= 8'h00;
      sh_out    <= 8'h00;
      cur_index <= 4'h0;
      chan_ok   <= 1'b0;
      nack      <= 1'b0;
      ack_phase <= 1'b0;
      rack_ok   <= 1'b0;
      peek_ok   <= 1'b0;
      sda_drive <= 1'b0;
      so_bit    <= 1'b0;
      so_en     <= 1'b0;
      wr_go     <= 1'b0;
      wr_byte   <= 8'h00;
      strap_a   <= 2'h0;
      strap_b   <= 2'h0;
      strap_c   <= 2'h0;
    end else begin
      wr_go <= 1'b0;
      so_en <= spi_mode & ~cs_s;
      if (scl_rise)
        sh_in <= byte_in;
      if (spi_mode & cs_s) begin
        state   <= ST_IDLE;
        bit_cnt <= 3'h0;
        so_bit  <= 1'b0;
      end else if (tw_start) begin
        state     <= ST_ADDR;
        bit_cnt   <= 3'h0;
        sda_drive <= 1'b0;
        strap_a   <= sync[2:1];
      end else if (tw_stop) begin
        state     <= ST_IDLE;
        sda_drive <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            // sampling at 25 MHz bounds the usable four-wire clock well below 33 MHz
            if (spi_mode & ~cs_s)
              state <= ST_SCMD;
          end
          ST_ADDR: begin
            if (scl_rise & bit_cnt == 3'h0)
              strap_b <= sync[2:1];
            if (scl_fall & bit_cnt == 3'h0)
              strap_c <= sync[2:1];
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
              if (byte_in[7:1] == own_addr7) begin
                state     <= ST_ACK;
                nack      <= 1'b0;
                ack_phase <= 1'b0;
                ack_next  <= byte_in[`TW_DIR_BIT] ? ST_RDATA : ST_SUB;
              end else
                state <= ST_IDLE;
            end
          end
          ST_ACK: begin
            if (scl_fall & ~ack_phase) begin
              sda_drive <= ~nack;
              ack_phase <= 1'b1;
            end else if (scl_fall) begin
              ack_phase <= 1'b0;
              bit_cnt   <= 3'h0;
              state     <= nack ? ST_IDLE : ack_next;
              if (ack_next == ST_RDATA & ~nack) begin
                sh_out    <= fetch_data;
                sda_drive <= ~fetch_data[7];
              end else
                sda_drive <= 1'b0;
            end
          end
          ST_SUB, ST_WDATA: begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
              state     <= ST_ACK;
              ack_phase <= 1'b0;
              ack_next  <= ST_WDATA;
              if (state == ST_SUB) begin
                // bits 7 and 0 are never looked at
                cur_index <= byte_in[`SUB_INDEX_MSB:`SUB_INDEX_LSB];
                chan_ok <= byte_in[`SUB_CHAN_MSB:`SUB_CHAN_LSB] == `SUB_CHAN_VALID;
                nack    <= byte_in[`SUB_CHAN_MSB:`SUB_CHAN_LSB] != `SUB_CHAN_VALID;
              end else if (is_fifo & ~buf_in_ready) begin
                nack <= 1'b1;
              end else begin
                nack    <= ~chan_ok;
                wr_go   <= chan_ok;
                wr_byte <= byte_in;
              end
            end
          end
          ST_RDATA: begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
              state     <= ST_RACK;
              ack_phase <= 1'b0;
            end else if (scl_fall) begin
              sda_drive <= ~sh_out[6];
              sh_out    <= {sh_out[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            if (scl_fall & ~ack_phase) begin
              sda_drive <= 1'b0;
              ack_phase <= 1'b1;
            end else if (scl_rise)
              rack_ok <= ~sda_s;
            else if (scl_fall) begin
              // master not-acknowledge ends the read; wait for stop or a new start
              state     <= rack_ok ? ST_RDATA : ST_IDLE;
              bit_cnt   <= 3'h0;
              ack_phase <= 1'b0;
              if (rack_ok) begin
                sh_out    <= fetch_data;
                sda_drive <= ~fetch_data[7];
              end
            end
          end
          ST_SCMD: begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            if (byte_done) begin
              cur_index <= byte_in[`SUB_INDEX_MSB:`SUB_INDEX_LSB];
              chan_ok   <= byte_in[`SUB_CHAN_MSB:`SUB_CHAN_LSB] == `SUB_CHAN_VALID;
              state     <= byte_in[`SPI_DIR_BIT] ? ST_SRD : ST_SWR;
            end
          end
          ST_SWR: begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            // no refusal path on four wires: a byte meeting a full stream is dropped
            if (byte_done) begin
              wr_go   <= chan_ok & ~(is_fifo & ~buf_in_ready);
              wr_byte <= byte_in;
            end
          end
          ST_SRD: begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 3'h1;
            if (load_now) begin
              sh_out <= chan_ok ? fetch_data : `RX_EMPTY_DATA;
              so_bit <= chan_ok ? fetch_data[7] : 1'b0;
              peek_ok <= chan_ok & is_fifo & rx_valid;
            end else if (scl_fall) begin
              so_bit <= sh_out[6];
              sh_out <= {sh_out[6:0], 1'b0};
            end
          end
          default: begin
            state     <= ST_IDLE;
            sda_drive <= 1'b0;
          end
        endcase
      end
    end
  end

  // two entries decouple the serial byte rate from a stalled uart transmit path
  pair_buffer #(
    .WIDTH (8),
    .DEPTH (BUF_DEPTH)
  ) tx_buffer (
    .clk       (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (wr_go & is_fifo),
    .in_ready  (buf_in_ready),
    .in_data   (wr_byte),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );
endmodule // serial_host_register_port

// ==== test/serial_host_chk.sv ====
// serial_host_chk.sv: port-level assertions for the serial host register port.
// assumes one sys_clk domain; attached by the bind after the module.
`timescale 1ns/1ps
module serial_host_chk (
  // clock and reset
  input wire       sys_clk, arst_n,
  // bus pins
  input wire       scl_in, spi_cs_n, sda_out, sda_oe, spi_so, spi_so_oe,
  // uart core side
  input wire       divisor_access, tx_valid, tx_ready, rx_valid, rx_ready, reg_wr,
  input wire [7:0] tx_data,
  input wire [3:0] reg_index
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  AST_RST_QUIET: assert property ($rose(arst_n) |-> !sda_oe && !spi_so_oe && !tx_valid)
    else $error("outputs active at reset release");
  AST_SDA_ZERO: assert property (sda_out == 1'b0)
    else $error("open-drain value not low");
  AST_SDA_HOLD: assert property ($rose(sda_oe) |-> sda_oe[*8])
    else $error("data line released early");
  AST_SDA_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved with clock high");
  AST_SO_CS: assert property ($rose(spi_cs_n) |-> ##[1:4] !spi_so_oe)
    else $error("output kept after deselect");
  AST_SO_FALL: assert property (spi_so_oe && $changed(spi_so) |-> !scl_in)
    else $error("output moved with clock high");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("stalled word lost");
  AST_RX_POP: assert property (rx_ready |-> rx_valid)
    else $error("pop of empty stream");
  AST_WR_IDX0: assert property (reg_wr |-> reg_index != 4'h0 || divisor_access)
    else $error("holding write bypassed stream");
endmodule // serial_host_chk

bind serial_host_register_port serial_host_chk u_chk (
  .sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl_in), .spi_cs_n(spi_cs_n),
  .sda_out(sda_out), .sda_oe(sda_oe), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
  .divisor_access(divisor_access), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .reg_wr(reg_wr), .tx_data(tx_data),
  .reg_index(reg_index));

// ==== test/host_master.sv ====
// host_master.sv: behavioural two-wire / four-wire bus master.
// assumes sda is the resolved open-drain wire; lines stand still between frames.
`timescale 1ns/1ps
module host_master #(
  // 640 ns quarter bit: about 390 kbps fast rate
  parameter Q = 640,
  // 33 MHz is beyond the port's sampling, so a 320 ns clock is used
  parameter H = 160
) (
  // driven lines
  output reg  scl, sda_low, cs_n, si,
  // observed lines
  input  wire sda, so
);
  task idle(input spi);
    begin
      scl = ~spi;
      sda_low = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
    end
  endtask
  task start;
    begin
      sda_low = 1'b0;
      #Q scl = 1'b1;
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
      #Q;
    end
  endtask
  task wbyte(input [7:0] b, output reg ack);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low = (i > 0) ? ~b[i-1] : 1'b0;
        #Q scl = 1'b1;
        #Q ack = ~sda;
        #Q scl = 1'b0;
        #Q;
      end
    end
  endtask
  task rbyte(output reg [7:0] b, input last);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        sda_low = (i == 0) && !last;
        #Q scl = 1'b1;
        #Q if (i > 0) b[i-1] = sda;
        #Q scl = 1'b0;
        #Q;
      end
      sda_low = 1'b0;
    end
  endtask
  task stop;
    begin
      sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
    end
  endtask
  task sbegin;
    begin
      cs_n = 1'b0;
      #H;
    end
  endtask
  task sbyte(input [7:0] b, output reg [7:0] r);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        si = b[i];
        #H scl = 1'b1;
        r[i] = so;
        #H scl = 1'b0;
      end
    end
  endtask
  task send;
    begin
      #H cs_n = 1'b1;
      // released input shows the inverse so stale data is never trusted
      si = ~si;
      #H;
    end
  endtask
endmodule // host_master

// ==== test/serial_host_register_port_tb_top.sv ====
// serial_host_register_port_tb_top.sv: self-checking bench for the serial host port.
// assumes host_master on the pins; queues stand in for the uart fifos.
`timescale 1ns/1ps
module serial_host_register_port_tb_top;
  reg         sys_clk, arst_n, spi_select, strap_h, strap_l, divisor_access, tx_ready, rx_valid, a;
  reg  [7:0]  rx_data, r, e, wr_dat;
  reg  [7:0]  d [0:2];
  reg  [7:0]  txq[$], rxq[$], expq[$];
  reg  [3:0]  wr_idx;
  reg  [31:0] seed;
  integer     fails, n_tests, j, k, n_rd;
  wire        scl, sda_low, cs_n, si, sda_out, sda_oe, spi_so, spi_so_oe;
  wire        tx_valid, rx_ready, reg_wr, reg_rd;
  wire [3:0]  reg_index;
  wire [7:0]  tx_data, reg_wdata, reg_rdata;
  // pull-up on the open-drain data wire
  wire        sda = ~(sda_oe | sda_low);
  assign reg_rdata = {4'hc, reg_index};

  serial_host_register_port u_serial_host_register_port (
    .sys_clk(sys_clk), .arst_n(arst_n), .scl_in(scl), .spi_select(spi_select),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .spi_cs_n(cs_n), .spi_si(si),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .addr_strap_high(strap_h),
    .addr_strap_low(strap_l), .divisor_access(divisor_access), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_index(reg_index),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  host_master u_host_master (
    .scl(scl), .sda_low(sda_low), .cs_n(cs_n), .si(si), .sda(sda), .so(spi_so));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // strap tied high codes 00, tied low 01
  function [7:0] adr(input h, input l);
    adr = 8'h90 | {3'h0, 1'b0, ~h, 1'b0, ~l, 1'b0};
  endfunction
  task rnd(output [7:0] v);
    begin
      seed = xs(seed);
      v = seed[7:0];
    end
  endtask
  task chk_bit(input got, input exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t ack %b exp %b", $time, got, exp);
      end
    end
  endtask
  task chk_byte(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("[ERR] %0t byte %h exp %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task rst(input mode);
    begin
      arst_n = 1'b0;
      spi_select = mode;
      u_host_master.idle(mode);
      repeat (6) @(negedge sys_clk);
      arst_n = 1'b1;
      repeat (6) @(negedge sys_clk);
    end
  endtask
  task tw_open(input [7:0] sub, input exp);
    begin
      u_host_master.start;
      u_host_master.wbyte(adr(strap_h, strap_l), a);
      chk_bit(a, 1'b1);
      u_host_master.wbyte(sub, a);
      chk_bit(a, exp);
    end
  endtask
  task tw_rd_open;
    begin
      u_host_master.start;
      u_host_master.wbyte(adr(strap_h, strap_l) | 8'h01, a);
      chk_bit(a, 1'b1);
    end
  endtask

  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) txq.push_back(tx_data);
    if (rx_ready && rx_valid) rxq.delete(0);
    if (reg_rd) n_rd = n_rd + 1;
    if (reg_wr) begin
      wr_idx = reg_index;
      wr_dat = reg_wdata;
    end
  end
  always @(negedge sys_clk) begin
    rx_valid = rxq.size() > 0;
    rx_data = rx_valid ? rxq[0] : 8'h00;
  end
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    fails = fails + 1;
    final_report;
  end

  initial begin
    fails = 0;
    n_tests = 0;
    n_rd = 0;
    seed = 32'h0000_0051;
    {strap_h, strap_l, divisor_access, tx_ready} = 4'h0;
    rst(1'b0);
    for (k = 0; k < 4; k = k + 1) begin
      {strap_h, strap_l} = k[1:0];
      tw_open(8'h81, 1'b1);
      for (j = 0; j < 3; j = j + 1) begin
        rnd(d[j]);
        u_host_master.wbyte(d[j], a);
        chk_bit(a, j < 2);
      end
      u_host_master.stop;
      tx_ready = 1'b1;
      repeat (4) @(negedge sys_clk);
      tx_ready = 1'b0;
      chk_byte(8'(txq.size()), 8'h02);
      for (j = 0; j < 2; j = j + 1) chk_byte(txq.pop_front(), d[j]);
    end
    $display("test two-wire stream write done");
    u_host_master.start;
    u_host_master.wbyte(adr(strap_h, strap_l) ^ 8'h04, a);
    chk_bit(a, 1'b0);
    tw_open(8'h0a, 1'b0);
    u_host_master.stop;
    $display("test two-wire refusals done");
    tw_open(8'h18, 1'b1);
    rnd(d[0]);
    u_host_master.wbyte(d[0], a);
    chk_byte({4'h0, wr_idx}, 8'h03);
    chk_byte(wr_dat, d[0]);
    tw_rd_open;
    u_host_master.rbyte(r, 1'b1);
    chk_byte(r, 8'hc3);
    chk_byte(n_rd[7:0], 8'h01);
    u_host_master.stop;
    $display("test register access done");
    for (j = 0; j < 2; j = j + 1) rnd(d[j]);
    rxq = {d[0], d[1]};
    tw_open(8'h00, 1'b1);
    tw_rd_open;
    for (j = 0; j < 3; j = j + 1) begin
      u_host_master.rbyte(r, j == 2);
      chk_byte(r, (j < 2) ? d[j] : 8'h00);
    end
    u_host_master.stop;
    $display("test two-wire read done");
    rst(1'b1);
    tx_ready = 1'b1;
    u_host_master.sbegin;
    u_host_master.sbyte(8'h00, r);
    for (j = 0; j < 64; j = j + 1) begin
      rnd(e);
      expq.push_back(e);
      u_host_master.sbyte(e, r);
    end
    u_host_master.send;
    chk_byte(8'(txq.size()), 8'h40);
    for (j = 0; j < 64; j = j + 1) chk_byte(txq.pop_front(), expq.pop_front());
    $display("test four-wire write done");
    for (j = 0; j < 65; j = j + 1) begin
      rnd(e);
      rxq.push_back(e);
    end
    @(negedge sys_clk);
    u_host_master.sbegin;
    u_host_master.sbyte(8'h80, r);
    for (j = 0; j < 64; j = j + 1) begin
      e = rxq[0];
      u_host_master.sbyte(8'h00, r);
      chk_byte(r, e);
    end
    u_host_master.send;
    u_host_master.sbegin;
    u_host_master.sbyte(8'h82, r);
    u_host_master.sbyte(8'h00, r);
    u_host_master.send;
    chk_byte(r, 8'h00);
    chk_byte(8'(rxq.size()), 8'h01);
    $display("test four-wire read done");
    final_report;
  end
endmodule // serial_host_register_port_tb_top
